// ===== hdl/pin_bank.sv
//Function
//R1: 24 pins as three 8-bit ports.
//R2: Pin-level register returns sampled pin levels.
//R3: Set and clear registers modify output level.
//R4: Per-port wake-enable register selects wake pins.
//R5: 4-bit mode fields in low/high registers.
//R6: Code 0x0 analog; reads constant one.
//R7: Code 0x4 floating input, driver off.
//R8: Code 0x8 pulled input; output bit picks direction.
//R9: Code 0x1 push-pull from output bit.
//R10: Code 0x5 open-drain, no internal pull.
//R11: Open-drain zero sinks, one tri-states.
//R12: Code 0x9 peripheral drives the pin.
//R13: Enabled timer channel beats serial output.
//R14: Route bits 4-7 pick port A/B pins.
//R15: Alternate pin without peripheral drives zero.
//R16: Debug-disable bit releases port C debug pins.
//R17: Regulator bit forces A7 open-drain enable.
//R18: Scan mode forces C0/C3/C4 pulled, C2 output.
//R19: Two-wire mode makes C4 debugger-driven bidirectional.
//R20: Full reset returns modes to floating input.
//R21: Full reset sets regulator, clears debug-disable.
//R22: A5 pulled up 512 RC periods, then sampled.
//R23: A5 then floats; sample kept readable.
//R24: Written ones act; written zeros ignored.
`timescale 1ns/1ps
`default_nettype none

module pin_bank
  import pin_bank_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  input  wire logic                          boot_strap_reset,
  // APB slave.
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  // Pads.
  input  wire logic [pin_bank_pkg::NUM_PINS-1:0] pad_in,
  output pin_bank_pkg::pad_ctrl_t            pad_ctrl,
  // Peripherals.
  input  wire logic [pin_bank_pkg::NUM_PINS-1:0] serial_out,
  input  wire logic [pin_bank_pkg::NUM_PINS-1:0] serial_present,
  input  wire logic [3:0]                    timer_two_channel,
  input  wire logic [3:0]                    timer_two_channel_enable,
  input  wire logic                          regulator_enable_signal,
  input  wire pin_bank_pkg::debug_if_t       debug_if,
  output logic [pin_bank_pkg::NUM_PINS-1:0]  pin_level_to_periph,
  output logic [pin_bank_pkg::NUM_PINS-1:0]  wake_enable,
  output logic                               boot_select_n,
  output logic                               boot_sample_done
);

  // ==========================================================================
  // Decoding helpers

  // Returns the mode field of pin p from the two configuration halves.
  function automatic logic [3:0] mode_of(input logic [15:0] lo, input logic [15:0] hi,
                                         input int p);
    logic [31:0] all;
    all = {hi, lo};
    return all[p*MODE_W +: MODE_W]; // R5
  endfunction

  // Returns the port index from address bits 7:6, with no range check.
  function automatic logic [1:0] port_of(input logic [11:0] a);
    logic [1:0] idx;
    idx = a[7:6];
    return idx;
  endfunction

  // ==========================================================================
  // Registers
  logic [7:0]  out_level_q [NUM_PORTS];
  logic [7:0]  wake_q      [NUM_PORTS];
  logic [15:0] mode_lo_q   [NUM_PORTS];
  logic [15:0] mode_hi_q   [NUM_PORTS];
  logic        ext_reg_en_q;
  logic        dbg_dis_q;
  logic [3:0]  route_q;
  logic [BOOT_CNT_W-1:0] boot_cnt_q;
  logic        boot_done_q;
  logic        boot_val_q;
  logic [7:0]  level_q     [NUM_PORTS];

  logic        acc_phase;
  logic        wr_en;
  logic [1:0]  wr_port;
  logic        port_hit;
  logic [5:0]  wr_ofs;

  assign acc_phase = psel && penable;
  assign wr_en     = acc_phase && pwrite;
  assign wr_port   = port_of(paddr);
  assign port_hit  = (paddr[11:8] == 4'h0) && (wr_port != 2'd3);
  assign wr_ofs    = paddr[5:0];

  // Per-port configuration and output registers.
  generate
    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
        begin
          out_level_q[g] <= RST_BYTE;
          wake_q[g]      <= RST_BYTE;
          mode_lo_q[g]   <= RST_MODE_HALF; // R20
          mode_hi_q[g]   <= RST_MODE_HALF; // R20
        end
        else if (wr_en && port_hit && (wr_port == 2'(g)))
        begin
          case (wr_ofs)
            OFS_OUTPUT_LEVEL:   out_level_q[g] <= pwdata[7:0];
            OFS_OUTPUT_CLEAR:   out_level_q[g] <= out_level_q[g] & ~pwdata[7:0]; // R3 R24
            OFS_OUTPUT_SET:     out_level_q[g] <= out_level_q[g] | pwdata[7:0];  // R3 R24
            OFS_WAKE_ENABLE:    wake_q[g]      <= pwdata[7:0]; // R4
            OFS_MODE_LOW_PINS:  mode_lo_q[g]   <= pwdata[15:0];
            OFS_MODE_HIGH_PINS: mode_hi_q[g]   <= pwdata[15:0];
            default:            out_level_q[g] <= out_level_q[g];
          endcase
        end
      end
    end
  endgenerate

  // Debug configuration and timer routing.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_reg_en_q <= 1'b1; // R21
      dbg_dis_q    <= 1'b0; // R21
      route_q      <= 4'h0;
    end
    else if (wr_en && paddr == ADDR_DEBUG_PIN_CONFIG)
    begin
      ext_reg_en_q <= pwdata[BIT_EXT_REGULATOR_ENABLE];
      dbg_dis_q    <= pwdata[BIT_DEBUG_PINS_DISABLE];
    end
    else if (wr_en && paddr == ADDR_TIMER_ROUTE)
    begin
      route_q <= pwdata[BIT_ROUTE_CH1 +: 4];
    end
  end

  // Boot-select window: count after release, then sample A5 once.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      boot_cnt_q  <= '0;
      boot_done_q <= 1'b1;
      boot_val_q  <= 1'b1;
    end
    else if (boot_strap_reset)
    begin
      boot_cnt_q  <= '0;
      boot_done_q <= 1'b0;
    end
    else if (!boot_done_q)
    begin
      if (boot_cnt_q == BOOT_CNT_W'(BOOT_DELAY_CYC - 1))
      begin
        boot_done_q <= 1'b1;      // R22
        boot_val_q  <= pad_in[5]; // R22 R23
      end
      else
      begin
        boot_cnt_q <= boot_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Per-pin mode resolution
  logic [NUM_PINS-1:0] alt_val, alt_have;
  logic [NUM_PINS-1:0] n_out, n_oe, n_pen, n_pup, n_in;
  logic [3:0]          tmode [NUM_PINS];

  // Timer channel pin targets per route bit.
  always_comb
  begin
    alt_val  = serial_out & serial_present;
    alt_have = serial_present;
    for (int c = 0; c < 4; c++)
    begin
      int pa;
      int pb;
      pa = (c == 0) ? 0 : (c == 1) ? 3 : (c == 2) ? 1 : 2; // R14
      pb = 9 + c;                                         // R14
      if (timer_two_channel_enable[c]) // R13
      begin
        if (route_q[c])
        begin
          alt_val[pb]  = timer_two_channel[c];
          alt_have[pb] = 1'b1;
        end
        else
        begin
          alt_val[pa]  = timer_two_channel[c];
          alt_have[pa] = 1'b1;
        end
      end
    end
  end

  generate
    for (genvar p = 0; p < NUM_PINS; p++)
    begin : g_pin
      // Decodes the effective mode of one pin into pad controls.
      always_comb
      begin
        logic [3:0] m;
        logic       ov;
        m  = mode_of(mode_lo_q[p/8], mode_hi_q[p/8], p%8);
        ov = out_level_q[p/8][p%8];
        tmode[p] = m;
        n_out[p] = 1'b0;
        n_oe[p]  = 1'b0;
        n_pen[p] = 1'b0;
        n_pup[p] = 1'b0;
        n_in[p]  = pad_in[p];
        case (m)
          MODE_ANALOG:   n_in[p] = 1'b1;                    // R6
          MODE_IN_FLOAT: n_oe[p] = 1'b0;                    // R7
          MODE_IN_PULL:
          begin
            n_pen[p] = 1'b1;                                // R8
            n_pup[p] = ov;                                  // R8
          end
          MODE_OUT_PP:
          begin
            n_oe[p]  = 1'b1;                                // R9
            n_out[p] = ov;
          end
          MODE_OUT_OD:  n_oe[p] = ~ov;                       // R10 R11
          MODE_ALT_PP:
          begin
            n_oe[p]  = 1'b1;                                // R12
            n_out[p] = alt_have[p] ? alt_val[p] : 1'b0;     // R15
          end
          default:       n_oe[p] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Forced functions override the decoded controls.
  pad_ctrl_t                      nxt;
  logic [NUM_PINS-1:0]            nxt_in;
  localparam int                  BOOT_PIN       = 5;
  localparam int                  REG_PIN        = 7;
  localparam int                  SCAN_OUT_PIN   = 18;
  localparam int                  SCAN_SEL_PIN   = 20;
  localparam logic [NUM_PINS-1:0] SCAN_PULL_MASK = 24'h190000; // Port C pins 0, 3 and 4.

  always_comb
  begin
    nxt.out     = n_out;
    nxt.oe      = n_oe;
    nxt.pull_en = n_pen;
    nxt.pull_up = n_pup;
    nxt_in      = n_in;
    if (ext_reg_en_q) // R17
    begin
      nxt.out[REG_PIN]     = 1'b0;
      nxt.oe[REG_PIN]      = ~regulator_enable_signal;
      nxt.pull_en[REG_PIN] = 1'b0;
      nxt_in[REG_PIN]      = pad_in[REG_PIN];
    end
    if (!dbg_dis_q && debug_if.scan_active) // R16 R18
    begin
      nxt.oe                    = nxt.oe & ~SCAN_PULL_MASK;
      nxt.pull_en               = nxt.pull_en | SCAN_PULL_MASK;
      nxt.pull_up               = nxt.pull_up | SCAN_PULL_MASK;
      nxt_in                    = (nxt_in & ~SCAN_PULL_MASK) | (pad_in & SCAN_PULL_MASK);
      nxt.oe[SCAN_OUT_PIN]      = 1'b1;
      nxt.out[SCAN_OUT_PIN]     = debug_if.scan_data_out;
      nxt.pull_en[SCAN_OUT_PIN] = 1'b0;
    end
    else if (!dbg_dis_q && debug_if.wire_active) // R16 R19
    begin
      nxt.oe[SCAN_SEL_PIN]      = debug_if.wire_data_oe;
      nxt.out[SCAN_SEL_PIN]     = debug_if.wire_data_out;
      nxt.pull_en[SCAN_SEL_PIN] = 1'b0;
      nxt_in[SCAN_SEL_PIN]      = pad_in[SCAN_SEL_PIN];
    end
    if (!boot_done_q) // R22
    begin
      nxt.oe[BOOT_PIN]      = 1'b0;
      nxt.pull_en[BOOT_PIN] = 1'b1;
      nxt.pull_up[BOOT_PIN] = 1'b1;
      nxt_in[BOOT_PIN]      = pad_in[BOOT_PIN];
    end
  end

  // Registered pad controls and sampled levels.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pad_ctrl            <= '0;
      pin_level_to_periph <= '0;
      level_q             <= '{default: 8'h00};
    end
    else
    begin
      pad_ctrl            <= nxt;
      pin_level_to_periph <= nxt_in;
      for (int k = 0; k < NUM_PORTS; k++)
        level_q[k] <= nxt_in[k*8 +: 8]; // R1 R2
    end
  end

  // Status outputs.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_enable      <= '0;
      boot_select_n    <= 1'b1;
      boot_sample_done <= 1'b0;
    end
    else
    begin
      wake_enable      <= {wake_q[2], wake_q[1], wake_q[0]}; // R4
      boot_select_n    <= boot_val_q;                       // R23
      boot_sample_done <= boot_done_q;
    end
  end

  // ==========================================================================
  // APB read path, zero-wait, error on unmapped addresses.
  logic [31:0] rd_d;
  logic        err_d;
  always_comb
  begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (port_hit)
    begin
      case (wr_ofs)
        OFS_PIN_LEVEL:      rd_d[7:0]  = level_q[wr_port];
        OFS_OUTPUT_LEVEL:   rd_d[7:0]  = out_level_q[wr_port];
        OFS_OUTPUT_CLEAR:   rd_d       = 32'h0000_0000;
        OFS_OUTPUT_SET:     rd_d       = 32'h0000_0000;
        OFS_WAKE_ENABLE:    rd_d[7:0]  = wake_q[wr_port];
        OFS_MODE_LOW_PINS:  rd_d[15:0] = mode_lo_q[wr_port];
        OFS_MODE_HIGH_PINS: rd_d[15:0] = mode_hi_q[wr_port];
        default:            err_d      = 1'b1;
      endcase
    end
    else if (paddr == ADDR_DEBUG_PIN_CONFIG)
    begin
      rd_d[BIT_EXT_REGULATOR_ENABLE] = ext_reg_en_q;
      rd_d[BIT_DEBUG_PINS_DISABLE]   = dbg_dis_q;
    end
    else if (paddr == ADDR_DEBUG_PIN_STATUS)
    begin
      rd_d[BIT_BOOT_SELECT_CAPTURED] = boot_val_q; // R23
    end
    else if (paddr == ADDR_TIMER_ROUTE)
    begin
      rd_d[BIT_ROUTE_CH1 +: 4] = route_q;
    end
    else
    begin
      err_d = 1'b1;
    end
  end

  // Answer registered in the setup cycle, so pready rises in the access phase.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_d : 32'h0000_0000;
      pslverr <= psel && !penable && err_d;
    end
  end

  // ==========================================================================
  // Assertions
  AST_ANALOG_READS_ONE: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
    (tmode[8] == MODE_ANALOG) |=> pin_level_to_periph[8])
    else $error("Analog pin did not read one.");
  AST_SET_WRITE: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
    (wr_en && port_hit && wr_port == 2'd1 && wr_ofs == OFS_OUTPUT_SET)
      |=> ((out_level_q[1] & $past(pwdata[7:0])) == $past(pwdata[7:0])))
    else $error("Set write did not set bits.");
  AST_CLEAR_WRITE: assert property (@(posedge clk_sys) disable iff (!resetn) // R24
    (wr_en && port_hit && wr_port == 2'd0 && wr_ofs == OFS_OUTPUT_CLEAR)
      |=> (out_level_q[0] == ($past(out_level_q[0]) & ~$past(pwdata[7:0]))))
    else $error("Clear write wrong.");
  AST_PP_DRIVE: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
    (tmode[11] == MODE_OUT_PP) |=> (pad_ctrl.oe[11] && pad_ctrl.out[11] == $past(out_level_q[1][3])))
    else $error("Push-pull pin not driven from output bit.");
  AST_OD_DRIVE: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
    (tmode[12] == MODE_OUT_OD) |=> (pad_ctrl.oe[12] == !$past(out_level_q[1][4]) && !pad_ctrl.out[12]))
    else $error("Open-drain pin wrong.");
  AST_ALT_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn) // R15
    (tmode[14] == MODE_ALT_PP && !serial_present[14]) |=> (pad_ctrl.oe[14] && !pad_ctrl.out[14]))
    else $error("Alternate pin without peripheral not zero.");
  AST_REG_FORCE: assert property (@(posedge clk_sys) disable iff (!resetn) // R17
    (resetn && ext_reg_en_q) |=> (pad_ctrl.oe[7] == !$past(regulator_enable_signal)))
    else $error("Regulator pin not forced.");
  AST_SCAN_FORCE: assert property (@(posedge clk_sys) disable iff (!resetn) // R18
    (!dbg_dis_q && debug_if.scan_active) |=> (pad_ctrl.oe[18] && pad_ctrl.pull_up[16]))
    else $error("Scan pins not forced.");
  AST_BOOT_PULL: assert property (@(posedge clk_sys) disable iff (!resetn) // R22
    (!boot_done_q) |=> (pad_ctrl.pull_up[5] && !pad_ctrl.oe[5]))
    else $error("Boot pin not pulled up.");

endmodule

`default_nettype wire

// ===== hdl/pin_bank_pkg.sv
package pin_bank_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_PORTS     = 3;
  localparam int PINS_PER_PORT = 8;
  localparam int NUM_PINS      = 24;
  localparam int MODE_W        = 4;

  // ==========================================================================
  // Register map, one 32-bit word each, port stride 0x40.
  localparam logic [11:0] PORT_STRIDE          = 12'h040;
  localparam logic [5:0]  OFS_PIN_LEVEL        = 6'h00;
  localparam logic [5:0]  OFS_OUTPUT_LEVEL     = 6'h04;
  localparam logic [5:0]  OFS_OUTPUT_CLEAR     = 6'h08;
  localparam logic [5:0]  OFS_OUTPUT_SET       = 6'h0c;
  localparam logic [5:0]  OFS_WAKE_ENABLE      = 6'h10;
  localparam logic [5:0]  OFS_MODE_LOW_PINS    = 6'h14;
  localparam logic [5:0]  OFS_MODE_HIGH_PINS   = 6'h18;
  localparam logic [11:0] ADDR_DEBUG_PIN_CONFIG = 12'h100;
  localparam logic [11:0] ADDR_DEBUG_PIN_STATUS = 12'h104;
  localparam logic [11:0] ADDR_TIMER_ROUTE      = 12'h108;

  // Field positions.
  localparam int BIT_EXT_REGULATOR_ENABLE = 4;
  localparam int BIT_DEBUG_PINS_DISABLE   = 5;
  localparam int BIT_BOOT_SELECT_CAPTURED = 3;
  localparam int BIT_ROUTE_CH1            = 4;

  // ==========================================================================
  // Mode codes.
  localparam logic [3:0] MODE_ANALOG    = 4'h0;
  localparam logic [3:0] MODE_IN_FLOAT  = 4'h4;
  localparam logic [3:0] MODE_IN_PULL   = 4'h8;
  localparam logic [3:0] MODE_OUT_PP    = 4'h1;
  localparam logic [3:0] MODE_OUT_OD    = 4'h5;
  localparam logic [3:0] MODE_ALT_PP    = 4'h9;

  // Reset values.
  localparam logic [15:0] RST_MODE_HALF = 16'h4444;
  localparam logic [7:0]  RST_BYTE      = 8'h00;

  // ==========================================================================
  // Boot-select delay: 512 RC periods; the RC period is a plain default.
  localparam int RC_PERIOD_NS  = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BOOT_DELAY_RC = 512;
  localparam int BOOT_DELAY_CYC =
    (BOOT_DELAY_RC * RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_CNT_W = 12;

  // Pad controls for one bank of 24 pins.
  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] pull_en;
    logic [NUM_PINS-1:0] pull_up;
  } pad_ctrl_t;

  // Debug port status from the debug interface.
  typedef struct packed {
    logic scan_active;
    logic wire_active;
    logic wire_data_out;
    logic wire_data_oe;
    logic scan_data_out;
  } debug_if_t;

endpackage

// ===== dv/pin_bank_board.sv
`timescale 1ns/1ps
`default_nettype none

module pin_bank_board
  import pin_bank_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire pin_bank_pkg::pad_ctrl_t pad_ctrl,
  input  wire logic [23:0]             ext_en,
  input  wire logic [23:0]             ext_val,
  output logic [23:0]                  pad_in
);
  logic [23:0] float_q = 24'h5a5a5a;

  // An undriven, unpulled line wanders so that a stale level never passes.
  always_ff @(posedge clk_sys)
  begin
    float_q <= ~float_q;
  end

  // Pad level: our driver, then the board driver, then the pull, else floating.
  always_comb
  begin
    for (int i = 0; i < 24; i++)
    begin
      if (pad_ctrl.oe[i])
        pad_in[i] = pad_ctrl.out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_ctrl.pull_en[i])
        pad_in[i] = pad_ctrl.pull_up[i];
      else
        pad_in[i] = float_q[i];
    end
  end
endmodule

`default_nettype wire

// ===== dv/test_pin_bank.sv
`timescale 1ns/1ps
`default_nettype none

module test_pin_bank;
  import pin_bank_pkg::*;
  logic             clk_sys = 1'b0;
  logic             resetn = 1'b0;
  logic             boot_strap_reset = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic             pready;
  logic [31:0]      prdata;
  logic             pslverr;
  logic [23:0]      pad_in;
  pad_ctrl_t        pad_ctrl;
  logic [23:0]      serial_out = 24'hffffff;
  logic [23:0]      serial_present = 24'hffbfff;
  logic [3:0]       timer_two_channel = 4'h0;
  logic [3:0]       timer_two_channel_enable = 4'h0;
  logic             regulator_enable_signal = 1'b0;
  debug_if_t        debug_if = 5'h00;
  logic [23:0]      ext_en = 24'h000000;
  logic [23:0]      ext_val = 24'h000000;
  logic [23:0]      pin_level_to_periph;
  logic [23:0]      wake_enable;
  logic             boot_select_n;
  logic             boot_sample_done;
  int               fails = 0;
  int               total_checks = 0;
  int               cyc = 0;

  always #5 clk_sys = ~clk_sys;

  pin_bank DUT (.clk_sys(clk_sys), .resetn(resetn), .boot_strap_reset(boot_strap_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pad_in(pad_in),
    .pad_ctrl(pad_ctrl), .serial_out(serial_out), .serial_present(serial_present),
    .timer_two_channel(timer_two_channel), .timer_two_channel_enable(timer_two_channel_enable),
    .regulator_enable_signal(regulator_enable_signal), .debug_if(debug_if),
    .pin_level_to_periph(pin_level_to_periph), .wake_enable(wake_enable),
    .boot_select_n(boot_select_n), .boot_sample_done(boot_sample_done));

  pin_bank_board board (.clk_sys(clk_sys), .pad_ctrl(pad_ctrl), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge, with an idle cycle after.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    chk({31'h0, n < 16}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  function automatic logic [11:0] adr(input int p, input logic [5:0] ofs);
    return 12'(p) * PORT_STRIDE + {6'h0, ofs};
  endfunction

  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    for (int p = 0; p < 3; p++)
    begin
      rd(adr(p, OFS_MODE_LOW_PINS), 32'h4444);
      rd(adr(p, OFS_MODE_HIGH_PINS), 32'h4444);
      rd(adr(p, OFS_OUTPUT_LEVEL), 32'h0);
    end
    rd(ADDR_DEBUG_PIN_CONFIG, 32'h10);
    chk(32'(boot_select_n), 32'h1);
  endtask

  // Set and clear registers touch only the bits written as one.
  task automatic t_set_clear();
    for (int p = 0; p < 3; p++)
    begin
      wr(adr(p, OFS_OUTPUT_LEVEL), 32'ha5);
      wr(adr(p, OFS_OUTPUT_SET), 32'h0f);
      rd(adr(p, OFS_OUTPUT_LEVEL), 32'haf);
      wr(adr(p, OFS_OUTPUT_CLEAR), 32'h81);
      rd(adr(p, OFS_OUTPUT_LEVEL), 32'h2e);
      rd(adr(p, OFS_OUTPUT_SET), 32'h0);
      wr(adr(p, OFS_WAKE_ENABLE), 32'(8'h3c ^ p));
      rd(adr(p, OFS_WAKE_ENABLE), 32'(8'h3c ^ p));
      chk(32'(wake_enable[p*8+:8]), 32'(8'h3c ^ p));
    end
  endtask

  // Port B: analog, float, pull-up, push-pull, open-drain 0/1, lone alt, pull-down.
  task automatic t_modes();
    ext_en  <= 24'h002200;
    ext_val <= 24'h002000;
    wr(adr(1, OFS_MODE_LOW_PINS), 32'h1840);
    wr(adr(1, OFS_MODE_HIGH_PINS), 32'h8955);
    wr(adr(1, OFS_OUTPUT_LEVEL), 32'h2c);
    rd(adr(1, OFS_MODE_HIGH_PINS), 32'h8955);
    settle();
    chk(32'(pad_ctrl.oe[15:8]), 32'h58);
    chk(32'(pad_ctrl.pull_en[15:8]), 32'h84);
    chk(32'(pad_ctrl.pull_up[15:8] & 8'h84), 32'h04);
    chk(32'(pad_ctrl.out[15:8] & 8'h58), 32'h08);
    rd(adr(1, OFS_PIN_LEVEL), 32'h2d);
    chk(32'(pin_level_to_periph[15:8]), 32'h2d);
  endtask

  // Timer channels beat serial outputs and follow the route bits.
  task automatic t_timer();
    logic [3:0] amask;
    wr(adr(0, OFS_MODE_LOW_PINS), 32'h9999);
    wr(adr(1, OFS_MODE_LOW_PINS), 32'h9990);
    wr(adr(1, OFS_MODE_HIGH_PINS), 32'h0009);
    for (int r = 0; r < 2; r++)
    begin
      wr(ADDR_TIMER_ROUTE, r ? 32'hf0 : 32'h0);
      for (int c = 0; c < 4; c++)
      begin
        timer_two_channel_enable <= 4'(1 << c);
        settle();
        amask = 4'(1 << (c == 0 ? 0 : c == 1 ? 3 : c == 2 ? 1 : 2));
        chk(32'(pad_ctrl.out[3:0]), r ? 32'hf : {28'h0, ~amask});
        chk(32'(pad_ctrl.out[12:9]), r ? {28'h0, ~4'(1 << c)} : 32'hf);
      end
    end
    timer_two_channel_enable <= 4'h0;
  endtask

  // Regulator pin and debug overrides on port C.
  task automatic t_forced();
    chk(32'({pad_ctrl.oe[7], pad_ctrl.out[7]}), 32'h2);
    regulator_enable_signal <= 1'b1;
    settle();
    chk(32'(pad_ctrl.oe[7]), 32'h0);
    regulator_enable_signal <= 1'b0;
    wr(ADDR_DEBUG_PIN_CONFIG, 32'h0);
    settle();
    chk(32'(pad_ctrl.oe[7]), 32'h0);
    for (int d = 0; d < 2; d++)
    begin
      debug_if <= debug_if_t'({4'b1000, 1'(d)});
      settle();
      chk(32'({pad_ctrl.oe[20:16], pad_ctrl.out[18]}), 32'({5'b00100, 1'(d)}));
      chk(32'(pad_ctrl.pull_en[20:16] & pad_ctrl.pull_up[20:16]), 32'h19);
    end
    debug_if <= debug_if_t'(5'b01110);
    settle();
    chk(32'({pad_ctrl.oe[20], pad_ctrl.out[20]}), 32'h3);
    debug_if <= debug_if_t'(5'b01000);
    settle();
    chk(32'({pad_ctrl.oe[20], pad_ctrl.pull_en[20]}), 32'h0);
    debug_if <= debug_if_t'(5'b10001);
    wr(ADDR_DEBUG_PIN_CONFIG, 32'h20);
    settle();
    chk(32'({pad_ctrl.oe[20:16], pad_ctrl.pull_en[20:16]}), 32'h0);
    rd(ADDR_DEBUG_PIN_CONFIG, 32'h20);
  endtask

  // Boot window with the strap pulled low by the board.
  task automatic t_boot();
    int n;
    n = 0;
    ext_en[5]        <= 1'b1;
    boot_strap_reset <= 1'b1;
    @(posedge clk_sys);
    boot_strap_reset <= 1'b0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (n == 3)
        chk(32'({pad_ctrl.pull_en[5], pad_ctrl.pull_up[5]}), 32'h3);
    end while ((n < 3 || boot_sample_done !== 1'b1) && n < 700);
    chk({31'h0, n >= BOOT_DELAY_CYC && n <= BOOT_DELAY_CYC + 4}, 32'h1);
    chk(32'(boot_select_n), 32'h0);
    settle();
    chk(32'({pad_ctrl.pull_en[5], pad_ctrl.oe[5]}), 32'h0);
    rd(ADDR_DEBUG_PIN_STATUS, 32'h0);
  endtask

  task automatic t_unmapped();
    logic [31:0] r;
    logic        e;
    apb(1'b1, 12'h0c4, 32'h1, r, e);
    chk(32'(e), 32'h1);
    apb(1'b0, 12'h1fc, 32'h0, r, e);
    chk(32'(e), 32'h1);
    rd(adr(0, OFS_OUTPUT_LEVEL), 32'h2e);
  endtask

  // ==========================================================================
  // Run control.
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, cyc, 0);
      conclude();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_set_clear();
    t_modes();
    t_timer();
    t_forced();
    t_boot();
    t_unmapped();
    conclude();
  end
endmodule

`default_nettype wire
